// file: fchd_pkg.sv
// Constants shared by the flash card host bus decoder.
// Assumes the decoder runs on one clock with host pins sampled asynchronously.
package fchd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions inside the sampled pin vector
  localparam int unsigned PIN_W      = 35;
  localparam int unsigned P_CE1      = 0;
  localparam int unsigned P_CE2      = 1;
  localparam int unsigned P_REG      = 2;
  localparam int unsigned P_OE       = 3;
  localparam int unsigned P_WE       = 4;
  localparam int unsigned P_IORD     = 5;
  localparam int unsigned P_IOWR     = 6;
  localparam int unsigned P_DMACK    = 7;
  localparam int unsigned P_ADDR     = 8;
  localparam int unsigned P_DAT      = 19;

  ////////////////////////////////////////////////////////////////////////////
  // Mapping configuration index values
  localparam logic [1:0] CFG_MEM     = 2'h0;
  localparam logic [1:0] CFG_IO_ANY  = 2'h1;
  localparam logic [1:0] CFG_IO_PRI  = 2'h2;
  localparam logic [1:0] CFG_IO_SEC  = 2'h3;

  // Address bits 9..3 of a task block and 9..1 of a control pair
  localparam logic [6:0] PRI_TASK_BLK = 7'h3e;
  localparam logic [6:0] SEC_TASK_BLK = 7'h2e;
  localparam logic [8:0] PRI_CTL_PAIR = 9'h1fb;
  localparam logic [8:0] SEC_CTL_PAIR = 9'h1bb;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets presented to the task file
  localparam logic [3:0] OFF_DATA    = 4'h0;
  localparam logic [3:0] OFF_ALT_CTL = 4'he;
  localparam logic [3:0] OFF_DRV_ADR = 4'hf;
  localparam logic [2:0] IDE_CTL_A   = 3'h6;
  localparam logic [2:0] IDE_DRV_A   = 3'h7;
  localparam logic [2:0] IDE_DATA_A  = 3'h0;
  localparam logic [2:0] WIN_PREFIX  = 3'h4;
  localparam logic [2:0] CTL_PREFIX  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [PIN_W-1:0] PIN_IDLE = 35'h0_0007_ffff;
  localparam logic [15:0] RST_DATA   = 16'h0000;
  localparam logic [3:0]  RST_OFF    = 4'h0;
  localparam logic [2:0]  STRAP_WAIT = 3'h5;

  typedef enum {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE,
    CYC_REFUSE
  } fchd_cyc_e;

endpackage : fchd_pkg

// file: fchd_decode.sv
// Host bus decoder of a removable flash card: lane steering, mode strap and
// register select for the task file behind it.
// Assumes the task file answers reads on rd_data within one clock and that
// the set-features logic drives byte_mode.
//
// What this block does
// - Card modes, low chip enable only: one byte on low lane, A0 picks even/odd.
// - Card modes, both chip enables: A0 ignored, word moves, odd high, even low.
// - Card modes, high chip enable only: odd byte on upper lane; lower lane unused.
// - Disk-interface mode only if output enable held low across power-up.
// - Disk-interface mode disables card socket protocol and configuration.
// - Disk-interface mode ignores memory and attribute space strobes.
// - Disk-interface mode accepts only task registers 1-7, data register and the second-select control block.
// - Set-features byte option narrows disk data transfers to eight bits.
// - Hot reinsertion with power on comes up in card ATA mode.
// - Data register PIO: select one, address 0, no DMA ack, full word.
// - DMA: ack with strobe, selects negated, address ignored; select+ack bad.
// - Second select: 6 is control/alt status, 7 drive address read.
// - Four mappings by index: memory, any I/O block, primary, secondary.
`timescale 1ns/10ps

module fchd_decode
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 ce1_n,
  input  wire logic                 ce2_n,
  input  wire logic                 reg_n,
  input  wire logic                 oe_n,
  input  wire logic                 we_n,
  input  wire logic                 iord_n,
  input  wire logic                 iowr_n,
  input  wire logic                 dmack_n,
  input  wire logic [10:0]          addr,
  input  wire logic [15:0]          dat_in,
  output logic      [15:0]          dat_out,
  output logic                      dat_hi_oe,
  output logic                      dat_lo_oe,
  input  wire logic [1:0]           cfg_index,
  input  wire logic                 hot_insert,
  input  wire logic                 byte_mode,
  output logic                      ide_mode,
  output logic                      acc_rd,
  output logic                      acc_wr,
  output logic                      acc_bad,
  output logic      [3:0]           acc_off,
  output logic                      acc_hi,
  output logic                      acc_lo,
  output logic                      acc_dma,
  output logic      [15:0]          acc_wdata,
  input  wire logic [15:0]          rd_data
);
  import fchd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, a bit moves once stages two and three agree
  logic [PIN_W-1:0] pin_vec;
  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s3_reg;
  logic [PIN_W-1:0] filt_reg;

  assign pin_vec = {dat_in, addr, dmack_n, iowr_n, iord_n, we_n, oe_n,
                    reg_n, ce2_n, ce1_n};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_reg   <= PIN_IDLE;
      s2_reg   <= PIN_IDLE;
      s3_reg   <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
    end
    else
    begin
      s1_reg   <= pin_vec;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
    end
  end

  logic        f_ce1;
  logic        f_ce2;
  logic        f_reg;
  logic        f_oe;
  logic        f_we;
  logic        f_iord;
  logic        f_iowr;
  logic        f_dmack;
  logic [10:0] f_addr;
  logic [15:0] f_dat;

  assign f_ce1   = filt_reg[P_CE1];
  assign f_ce2   = filt_reg[P_CE2];
  assign f_reg   = filt_reg[P_REG];
  assign f_oe    = filt_reg[P_OE];
  assign f_we    = filt_reg[P_WE];
  assign f_iord  = filt_reg[P_IORD];
  assign f_iowr  = filt_reg[P_IOWR];
  assign f_dmack = filt_reg[P_DMACK];
  assign f_addr  = filt_reg[P_ADDR +: 11];
  assign f_dat   = filt_reg[P_DAT +: 16];

  ////////////////////////////////////////////////////////////////////////////
  // Mode strap, caught after reset release once the sampler has settled
  logic [2:0] strap_cnt_reg;
  logic       strap_done_reg;
  logic       ide_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strap_cnt_reg  <= 3'h0;
      strap_done_reg <= 1'b0;
      ide_reg        <= 1'b0;
    end
    else if (hot_insert)
    begin
      strap_done_reg <= 1'b1;
      ide_reg        <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      if (strap_cnt_reg == STRAP_WAIT)
      begin
        strap_done_reg <= 1'b1;
        ide_reg        <= !f_oe;
      end
    end
  end

  assign ide_mode = ide_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Card-mode register select for each mapping; bit 4 marks a hit
  function automatic logic [4:0] card_map
  (
    input logic [1:0]  cfg,
    input logic [10:0] a,
    input logic        a0
  );
    logic [4:0] res;
    res = 5'h00;
    case (cfg)
      CFG_MEM:
      begin
        if (a[10])
          res = {1'b1, WIN_PREFIX, a0};
        else
          res = {1'b1, a[3:1], a0};
      end
      CFG_IO_ANY:
        res = {1'b1, a[3:1], a0};
      CFG_IO_PRI, CFG_IO_SEC:
      begin
        if (a[9:3] == ((cfg == CFG_IO_PRI) ? PRI_TASK_BLK : SEC_TASK_BLK))
          res = {2'b10, a[2:1], a0};
        else if (a[9:1] == ((cfg == CFG_IO_PRI) ? PRI_CTL_PAIR
                                                : SEC_CTL_PAIR))
          res = {1'b1, CTL_PREFIX, a0};
      end
      default:
        res = 5'h00;
    endcase
    return res;
  endfunction : card_map

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode from the filtered pins
  logic       hit;
  logic       cyc_rd;
  logic       cyc_wr;
  logic       lane_hi;
  logic       lane_lo;
  logic       is_dma;
  logic [3:0] off;
  logic       eff_a0;
  logic [4:0] cmap;

  always_comb
  begin
    hit     = 1'b0;
    cyc_rd  = 1'b0;
    cyc_wr  = 1'b0;
    lane_hi = 1'b0;
    lane_lo = 1'b0;
    is_dma  = 1'b0;
    off     = RST_OFF;
    // Word ignores A0; high-only forces odd byte
    eff_a0  = f_ce1 ? 1'b1 : (f_ce2 ? f_addr[0] : 1'b0);
    cmap    = card_map(cfg_index, f_addr, eff_a0);
    if (ide_reg)
    begin
      // Socket protocol off: only I/O strobes count
      cyc_rd = !f_iord;
      cyc_wr = !f_iowr;
      if (!f_dmack)
      begin
        if (f_ce1 && f_ce2)
        begin
          hit     = 1'b1;
          is_dma  = 1'b1;
          off     = OFF_DATA;
          lane_lo = 1'b1;
          lane_hi = !byte_mode;
        end
      end
      else if (!f_ce1 && f_ce2)
      begin
        hit     = 1'b1;
        off     = {1'b0, f_addr[2:0]};
        lane_lo = 1'b1;
        // Address 0 is the word-wide data register
        lane_hi = (f_addr[2:0] == IDE_DATA_A) && !byte_mode;
      end
      // Control block on the second select
      else if (f_ce1 && !f_ce2)
      begin
        lane_lo = 1'b1;
        if (f_addr[2:0] == IDE_CTL_A)
        begin
          hit = 1'b1;
          off = OFF_ALT_CTL;
        end
        else if (f_addr[2:0] == IDE_DRV_A && !cyc_wr)
        begin
          hit = 1'b1;
          off = OFF_DRV_ADR;
        end
      end
    end
    else if (!(f_ce1 && f_ce2))
    begin
      lane_lo = !f_ce1;
      lane_hi = !f_ce2;
      off     = cmap[3:0];
      // Mapping index picks memory or I/O strobes
      if (cfg_index == CFG_MEM)
      begin
        cyc_rd = !f_oe;
        cyc_wr = !f_we;
        hit    = f_reg && cmap[4];
      end
      else
      begin
        cyc_rd = !f_iord;
        cyc_wr = !f_iowr;
        hit    = !f_reg && cmap[4];
      end
    end
  end

  // Memory strobes in disk mode never reach the decode above
  logic cyc_any;
  assign cyc_any = cyc_rd || cyc_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer: read opens at strobe start, write commits at its end
  fchd_cyc_e cyc_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cyc_reg <= CYC_IDLE;
    else
    begin
      case (cyc_reg)
        CYC_IDLE:
        begin
          // Strobes during the strap window are dropped, mode is unknown
          if (strap_done_reg && cyc_any)
          begin
            // Both strobes or a refused select is invalid
            if (!hit || (cyc_rd && cyc_wr))
              cyc_reg <= CYC_REFUSE;
            else if (cyc_rd)
              cyc_reg <= CYC_READ;
            else
              cyc_reg <= CYC_WRITE;
          end
        end
        CYC_READ:
        begin
          if (!cyc_rd)
            cyc_reg <= CYC_IDLE;
        end
        CYC_WRITE:
        begin
          if (!cyc_wr)
            cyc_reg <= CYC_IDLE;
        end
        CYC_REFUSE:
        begin
          if (!cyc_any)
            cyc_reg <= CYC_IDLE;
        end
        default:
          cyc_reg <= CYC_IDLE;
      endcase
    end
  end

  logic start;
  assign start = (cyc_reg == CYC_IDLE) && strap_done_reg && cyc_any;

  ////////////////////////////////////////////////////////////////////////////
  // Access attributes latched at cycle start
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_off <= RST_OFF;
      acc_hi  <= 1'b0;
      acc_lo  <= 1'b0;
      acc_dma <= 1'b0;
    end
    else if (start)
    begin
      acc_off <= off;
      acc_hi  <= lane_hi;
      acc_lo  <= lane_lo;
      acc_dma <= is_dma;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_rd  <= 1'b0;
      acc_bad <= 1'b0;
    end
    else
    begin
      acc_rd  <= start && hit && cyc_rd && !cyc_wr;
      acc_bad <= start && (!hit || (cyc_rd && cyc_wr));
    end
  end

  // Write data taken as the strobe releases, so the bus has settled
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_wr    <= 1'b0;
      acc_wdata <= RST_DATA;
    end
    else
    begin
      acc_wr <= (cyc_reg == CYC_WRITE) && !cyc_wr;
      if ((cyc_reg == CYC_WRITE) && !cyc_wr)
        // Unused lower lane ignored on odd-only writes
        acc_wdata <= {acc_hi ? f_dat[15:8] : 8'h00,
                      acc_lo ? f_dat[7:0]  : 8'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read drive: lanes enabled only while the read strobe stands
  logic rd_live;
  assign rd_live = (cyc_reg == CYC_READ) && cyc_rd;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dat_out   <= RST_DATA;
      dat_hi_oe <= 1'b0;
      dat_lo_oe <= 1'b0;
    end
    else
    begin
      dat_hi_oe <= rd_live && acc_hi;
      dat_lo_oe <= rd_live && acc_lo;
      if (rd_live)
        dat_out <= rd_data;
    end
  end

endmodule : fchd_decode

// file: fchd_decode_checker.sv
// Concurrent checks on the host bus decoder ports.
// Assumes it is bound to fchd_decode and sees only its ports.
`timescale 1ns/10ps
module fchd_decode_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       ce1_n,
  input wire logic       ce2_n,
  input wire logic       dmack_n,
  input wire logic       hot_insert,
  input wire logic       byte_mode,
  input logic            ide_mode,
  input logic            acc_rd,
  input logic            acc_wr,
  input logic            acc_bad,
  input logic      [3:0] acc_off,
  input logic            acc_hi,
  input logic            acc_lo,
  input logic            acc_dma,
  input logic            dat_hi_oe,
  input logic            dat_lo_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = acc_rd | acc_wr;
  ////////////////////////////////////////////////////////////////////////////
  // idle pins quiet
  property p_idle;
    (ce1_n && ce2_n && dmack_n)[*8] |-> !acc_rd && !acc_bad;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pulse without any select");
  property p_word;
    acc && !ide_mode && acc_hi && acc_lo |-> !acc_off[0];
  endproperty
  a_word: assert property (p_word)
    else $error("word access on odd offset");
  property p_odd;
    acc && !ide_mode && acc_hi && !acc_lo |-> acc_off[0];
  endproperty
  a_odd: assert property (p_odd)
    else $error("upper lane byte not odd");
  property p_rd_lanes;
    acc_rd |=> dat_lo_oe == acc_lo && dat_hi_oe == acc_hi;
  endproperty
  a_rd_lanes: assert property (p_rd_lanes)
    else $error("read lane enables differ from access");
  property p_dma;
    acc && acc_dma |-> acc_off == 4'h0 && acc_lo && acc_hi == !byte_mode;
  endproperty
  a_dma: assert property (p_dma)
    else $error("bad DMA attributes");
  property p_task;
    ide_mode && acc && !acc_dma && acc_off != 4'h0 |-> acc_lo && !acc_hi;
  endproperty
  a_task: assert property (p_task)
    else $error("task register not byte wide");
  property p_data;
    ide_mode && acc && acc_off == 4'h0 && !byte_mode |-> acc_hi && acc_lo;
  endproperty
  a_data: assert property (p_data)
    else $error("data register not word wide");
  property p_hot;
    hot_insert |=> !ide_mode;
  endproperty
  a_hot: assert property (p_hot)
    else $error("disk mode after reinsertion");
  property p_keep;
    ide_mode && !hot_insert |=> ide_mode;
  endproperty
  a_keep: assert property (p_keep)
    else $error("disk mode dropped");
endmodule : fchd_decode_checker

bind fchd_decode fchd_decode_checker u_chk (
  .ref_clk, .rst, .ce1_n, .ce2_n, .dmack_n, .hot_insert, .byte_mode,
  .ide_mode, .acc_rd, .acc_wr, .acc_bad, .acc_off, .acc_hi, .acc_lo,
  .acc_dma, .dat_hi_oe, .dat_lo_oe
);

// file: fchd_host.sv
// Host controller model: one strobed cycle per call of run.
// Assumes one directly attached card on the bench clock.
// interrupt line left to the host, not modelled
`timescale 1ns/10ps
module fchd_host (
  input wire logic   ref_clk,
  output logic       ce1_n,
  output logic       ce2_n,
  output logic       reg_n,
  output logic       oe_n,
  output logic       we_n,
  output logic       iord_n,
  output logic       iowr_n,
  output logic       dmack_n,
  output logic [10:0] addr,
  output logic [15:0] dat_in
);
  logic        drv = 1'b0;
  logic [15:0] wd = 16'h0000;
  initial {ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, dmack_n} = 8'hff;
  initial addr = 11'h000;
  initial dat_in = 16'h0000;
  // Released bus toggles so a stale value is never mistaken for data
  always @(posedge ref_clk)
    dat_in <= drv ? wd : ~dat_in;
  task strap(input logic v);
    @(posedge ref_clk);
    oe_n <= v;
  endtask : strap
  task run(input logic c1n, c2n, rgn, dmn, input logic [1:0] st,
           input logic [10:0] a, input logic [15:0] d);
    wd = d;
    drv = st[0];
    @(posedge ref_clk);
    {ce1_n, ce2_n, reg_n, dmack_n} <= {c1n, c2n, rgn, dmn};
    addr <= a;
    @(posedge ref_clk);
    case (st)
      2'd0: oe_n <= 1'b0;
      2'd1: we_n <= 1'b0;
      2'd2: iord_n <= 1'b0;
      default: iowr_n <= 1'b0;
    endcase
    repeat (8) @(posedge ref_clk);
    {oe_n, we_n, iord_n, iowr_n} <= 4'hf;
    repeat (8) @(posedge ref_clk);
    {ce1_n, ce2_n, dmack_n} <= 3'h7;
    repeat (3) @(posedge ref_clk);
    drv = 1'b0;
  endtask : run
endmodule : fchd_host

// file: testbench.sv
// Self-checking bench for the host bus decoder.
// Assumes fchd_host drives the pins and the checker is bound.
`timescale 1ns/10ps
module testbench;
  import fchd_pkg::*;
  logic        ref_clk = 0, rst = 1, hot_insert = 0, byte_mode = 0;
  logic [1:0]  cfg_index = 0, cfg = 0;
  logic [15:0] rd_data = 0, rd_prev = 0, dat_in, dat_out, acc_wdata;
  // Only lanes that the card drives carry meaningful read data
  wire  [15:0] lane_m = {{8{dat_hi_oe}}, {8{dat_lo_oe}}};
  logic        ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, dmack_n;
  logic [10:0] addr, a;
  logic        dat_hi_oe, dat_lo_oe, ide_mode, acc_rd, acc_wr, acc_bad;
  logic [3:0]  acc_off;
  logic        acc_hi, acc_lo, acc_dma, ide_exp = 0, bm = 0;
  logic [24:0] got = 0;
  int          error_cnt = 0, n_compared = 0, cyc = 0, i, c;
  always #2 ref_clk = ~ref_clk;
  fchd_decode fchd_decode_i (.ref_clk, .rst, .ce1_n, .ce2_n, .reg_n,
    .oe_n, .we_n, .iord_n, .iowr_n, .dmack_n, .addr, .dat_in, .dat_out,
    .dat_hi_oe, .dat_lo_oe, .cfg_index, .hot_insert, .byte_mode, .ide_mode,
    .acc_rd, .acc_wr, .acc_bad, .acc_off, .acc_hi, .acc_lo, .acc_dma,
    .acc_wdata, .rd_data);
  fchd_host fchd_host_i (.ref_clk, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n,
    .iord_n, .iowr_n, .dmack_n, .addr, .dat_in);
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  always @(posedge ref_clk)
  begin
    rd_data <= 16'($urandom);
    rd_prev <= rd_data;
    if (dat_hi_oe || dat_lo_oe)
      cmp({9'h0, dat_out & lane_m}, {9'h0, rd_prev & lane_m});
    cyc <= cyc + 1;
    if (acc_rd) got <= {2'd1, acc_off, acc_hi, acc_lo, acc_dma, 16'h0};
    if (acc_wr) got <= {2'd2, acc_off, acc_hi, acc_lo, acc_dma, acc_wdata};
    if (acc_bad) got <= {2'd3, 23'h0};
    if (cyc > 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic cmp(input logic [24:0] g, x);
    n_compared++;
    if (g !== x)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp
  // Kind 1 read, 2 write, 3 refused; 0 means no pulse at all
  function automatic logic [24:0] model(input logic c1n, c2n, rgn, dmn,
    input logic [1:0] st, input logic [10:0] a, input logic [15:0] d);
    logic [1:0] k;
    logic [3:0] o;
    logic h, l, m, z;
    k = st[0] ? 2'd2 : 2'd1;
    h = !c2n;
    l = !c1n;
    m = 0;
    o = 0;
    z = c1n | (c2n & a[0]);
    if (c1n && c2n && dmn) k = 0;
    else if (ide_exp)
    begin
      l = 1;
      h = 0;
      if (!st[1]) k = 0;
      else if (!dmn)
      begin
        if (!c1n || !c2n) k = 3;
        m = 1;
        h = !bm;
      end
      else if (!c1n)
      begin
        o = {1'b0, a[2:0]};
        h = a[2:0] == 0 && !bm;
      end
      else if (a[2:0] == 6) o = OFF_ALT_CTL;
      else if (a[2:0] == 7 && !st[0]) o = OFF_DRV_ADR;
      else k = 3;
    end
    else if ((cfg == CFG_MEM) != rgn) k = 3;
    else if (cfg == CFG_MEM && a[10]) o = {3'b100, z};
    else if (cfg < CFG_IO_PRI) o = {a[3:1], z};
    else if (a[9:3] == (cfg[0] ? SEC_TASK_BLK : PRI_TASK_BLK))
      o = {1'b0, a[2:1], z};
    else if (a[9:1] == (cfg[0] ? SEC_CTL_PAIR : PRI_CTL_PAIR))
      o = {3'b111, z};
    else k = 3;
    if (k == 0 || k == 3) return {k, 23'h0};
    return {k, o, h, l, m, st[0] ? {h ? d[15:8] : 8'h0, l ? d[7:0] : 8'h0}
                                 : 16'h0};
  endfunction : model
  task chk(input logic c1n, c2n, rgn, dmn, input logic [1:0] st,
           input logic [10:0] a, input logic [15:0] d);
    cfg_index <= cfg;
    byte_mode <= bm;
    got = 0;
    fchd_host_i.run(c1n, c2n, rgn, dmn, st, a, d);
    cmp(got, model(c1n, c2n, rgn, dmn, st, a, d));
  endtask : chk
  task boot(input logic s);
    fchd_host_i.strap(s);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    repeat (10) @(posedge ref_clk);
    fchd_host_i.strap(1'b1);
    repeat (6) @(posedge ref_clk);
    ide_exp = !s;
    cmp({24'h0, ide_mode}, {24'h0, ide_exp});
  endtask : boot
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'ha9995dec));
    boot(1'b1);
    chk(0, 1, 1, 1, 0, 11'h000, 0);
    chk(0, 1, 1, 1, 0, 11'h001, 0);
    chk(0, 1, 1, 1, 1, 11'h00d, 16'ha5c3);
    chk(0, 0, 1, 1, 0, 11'h003, 0);
    chk(0, 0, 1, 1, 1, 11'h401, 16'h1234);
    chk(1, 0, 1, 1, 0, 11'h006, 0);
    chk(1, 0, 1, 1, 1, 11'h000, 16'hbeef);
    chk(1, 1, 1, 1, 0, 11'h000, 0);
    chk(0, 1, 0, 1, 0, 11'h000, 0);
    for (i = 0; i < 12; i++)
    begin
      cfg = 2'(1 + i % 3);
      a = 11'($urandom);
      case (i % 4)
        1: a[9:3] = PRI_TASK_BLK;
        2: a[9:1] = SEC_CTL_PAIR;
        3: a[9:3] = SEC_TASK_BLK;
        default: ;
      endcase
      c = $urandom_range(2, 0);
      chk(c == 2, c == 1, 0, 1, 2'(2 + i % 2), a, 16'($urandom));
    end
    cfg = CFG_MEM;
    boot(1'b0);
    chk(0, 1, 1, 1, 2, 11'h000, 0);
    chk(0, 1, 1, 1, 3, 11'h000, 16'h55aa);
    for (i = 1; i < 8; i++)
      chk(0, 1, 1, 1, 2'(2 + i % 2), 11'(i), 16'($urandom));
    chk(0, 1, 1, 1, 0, 11'h003, 0);
    chk(1, 0, 1, 1, 2, 11'h006, 0);
    chk(1, 0, 1, 1, 3, 11'h006, 16'h0004);
    chk(1, 0, 1, 1, 2, 11'h007, 0);
    chk(1, 0, 1, 1, 3, 11'h007, 16'h0001);
    chk(1, 0, 1, 1, 2, 11'h005, 0);
    chk(1, 1, 1, 0, 2, 11'h7ff, 0);
    chk(1, 1, 1, 0, 3, 11'h123, 16'hc0de);
    chk(0, 1, 1, 0, 2, 11'h000, 0);
    bm = 1;
    chk(1, 1, 1, 0, 3, 11'h000, 16'h9876);
    chk(0, 1, 1, 1, 2, 11'h000, 0);
    bm = 0;
    hot_insert <= 1;
    @(posedge ref_clk);
    hot_insert <= 0;
    repeat (2) @(posedge ref_clk);
    ide_exp = 0;
    cmp({24'h0, ide_mode}, 25'h0);
    chk(0, 0, 1, 1, 0, 11'h000, 0);
    end_sim();
  end
endmodule : testbench
